// [verilog/pcs_map.svh]
// Register map, field positions and reset values of the power and clock bank
`ifndef PCS_MAP_SVH
`define PCS_MAP_SVH

// Register indices; byte address is four times the index
`define IDX_AMP_BUFFER     8'h30
`define IDX_BLOCK_POWER    8'h31
`define IDX_OSC_TRIM       8'h32
`define IDX_EXCITATION     8'h33
`define IDX_CLOCK_STATUS   8'h34

// Writable bits of each register
`define MASK_AMP_BUFFER    16'h0003
`define MASK_BLOCK_POWER   16'h1133
`define MASK_OSC_TRIM      16'h1f01
`define MASK_EXCITATION    16'h0007

// Field positions
`define BIT_AMP1_BUF       0
`define BIT_AMP2_BUF       1
`define BIT_FLASH_PWR      12
`define BIT_ADC_PWR        8
`define BIT_CONV2_PWR      5
`define BIT_CONV1_PWR      4
`define BIT_AMP2_PWR       1
`define BIT_AMP1_PWR       0
`define POS_TRIM_LSB       8
`define POS_TRIM_MSB       12
`define BIT_CLK_OUT_EN     0
`define POS_ISRC_MSB       2
`define BIT_STAT_INTERNAL  0
`define BIT_STAT_RUNNING   1
`define BIT_STAT_DRIVING   2

// Reset values
`define RST_AMP_BUFFER     16'h0000
`define RST_BLOCK_POWER    16'h0000
`define RST_OSC_TRIM       16'h0000
`define RST_EXCITATION     16'h0000

// Excitation current step, in microamps
`define ISRC_STEP_UA       12'h0a7

`endif

// [verilog/pcs_pkg.sv]
// Types shared by the power and clock bank
`default_nettype none

package pcs_pkg;

    typedef enum logic [1:0] {
        CLK_EXTERNAL,
        CLK_INT_QUIET,
        CLK_INT_DRIVE
    } clock_mode_type;

    typedef logic [15:0] reg_word_type;

endpackage

`default_nettype wire

// [verilog/pcs_clock_if.sv]
// Control and status between the register bank and the clock pin logic
`timescale 1ns/1ps
`default_nettype none

interface pcs_clock_if;
    logic clock_out_drive_en;
    logic internal_sel;
    logic osc_running;
    logic pin_driving;

    modport bank (output clock_out_drive_en, input internal_sel, osc_running, pin_driving);
    modport pin  (input clock_out_drive_en, output internal_sel, osc_running, pin_driving);
endinterface

`default_nettype wire

// [verilog/pcs_clock_pin.sv]
// Clock source strap, oscillator run control and shared clock pin driver
`timescale 1ns/1ps
`default_nettype none

module pcs_clock_pin
    import pcs_pkg::*;
(
    input  wire logic   pclk,
    input  wire logic   presetn,
    input  wire logic   clock_source_strap,
    input  wire logic   shared_clock_pin_i,
    output logic        shared_clock_pin_o,
    output logic        shared_clock_pin_oe,
    output logic        pin_clock_sync,
    pcs_clock_if.pin    ctl
);

    logic           strap_meta_q;
    logic           strap_q;
    logic           pin_meta_q;
    logic           pin_q;
    logic           osc_div_q;
    logic           run_q;
    logic           drive_q;
    clock_mode_type mode;

    // Strap and pin are asynchronous; two flops before use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_meta_q <= 1'b0;
            strap_q      <= 1'b0;
            pin_meta_q   <= 1'b0;
            pin_q        <= 1'b0;
        end else begin
            strap_meta_q <= clock_source_strap;
            strap_q      <= strap_meta_q;
            pin_meta_q   <= shared_clock_pin_i;
            pin_q        <= pin_meta_q;
        end
    end

    assign mode = !strap_q ? CLK_EXTERNAL :
                  ctl.clock_out_drive_en ? CLK_INT_DRIVE : CLK_INT_QUIET;

    // Divided stand-in for the internal oscillator; held at zero while halted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q     <= 1'b0;
            drive_q   <= 1'b0;
            osc_div_q <= 1'b0;
        end else begin
            case (mode)
                CLK_EXTERNAL: begin
                    run_q   <= 1'b0;
                    drive_q <= 1'b0;
                end
                CLK_INT_QUIET: begin
                    run_q   <= 1'b1;
                    drive_q <= 1'b0;
                end
                CLK_INT_DRIVE: begin
                    run_q   <= 1'b1;
                    drive_q <= 1'b1;
                end
                default: begin
                    run_q   <= 1'b0;
                    drive_q <= 1'b0;
                end
            endcase
            osc_div_q <= run_q ? ~osc_div_q : 1'b0;
        end
    end

    assign shared_clock_pin_o  = osc_div_q;
    assign shared_clock_pin_oe = drive_q;
    // External clock passed on in every mode; the strap is not consulted
    assign pin_clock_sync      = pin_q;
    assign ctl.internal_sel    = strap_q;
    assign ctl.osc_running     = run_q;
    assign ctl.pin_driving     = drive_q;

endmodule // pcs_clock_pin

`default_nettype wire

// [verilog/power_clock_source_control.sv]
// APB register bank for block power, oscillator trim and excitation current
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_map.svh"

// Function
// - Three-bit excitation code in bits 2..0, each step adds -167 uA.
// - Bit 12 enables power to flash write and erase circuitry.
// - Bit 8 powers the input converter.
// - Bit 5 powers output converter two, bit 4 converter one.
// - Bits 1 and 0 power amp pairs two and one; off means outputs float.
// - An enabled output converter forces its amps powered and buffered.
// - Five-bit two's-complement oscillator trim in bits 12..8, zero nominal.
// - Clock-out enable at bit 0 acts only with internal oscillator strapped.
// - Strap low halts the oscillator and makes the clock pin an input.
// - Strap high, enable low: oscillator runs, clock pin driver off.
// - Strap high, enable high: oscillator runs and drives the clock pin.
// - One buffer-mode bit per amp pair; one means buffer configuration.

module power_clock_source_control
    import pcs_pkg::*;
(
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic [11:0]         paddr,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [31:0]         pwdata,
    input  wire logic [3:0]          pstrb,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                clock_source_strap,
    input  wire logic                shared_clock_pin_i,
    output logic                     shared_clock_pin_o,
    output logic                     shared_clock_pin_oe,
    output logic                     pin_clock_sync,
    output logic                     flash_program_power_en,
    output logic                     converter_in_power_en,
    output logic                     out_conv1_power_en,
    output logic                     out_conv2_power_en,
    output logic                     amp_pair1_power_en,
    output logic                     amp_pair2_power_en,
    output logic                     amp_pair1_buffer_mode,
    output logic                     amp_pair2_buffer_mode,
    output logic                     osc_run,
    output logic      [4:0]          osc_trim_code,
    output logic      [2:0]          excitation_current_code,
    output logic signed [11:0]       excitation_current_ua
);

    // Byte address of a register index
    function automatic logic [11:0] byte_addr(input logic [7:0] idx);
        byte_addr = {2'b00, idx, 2'b00};
    endfunction

    // Merge enabled low byte lanes, then drop bits that do not exist
    function automatic reg_word_type lane_merge(
        input reg_word_type old_val,
        input logic [31:0]  wdata,
        input logic [3:0]   strb,
        input reg_word_type mask
    );
        reg_word_type lanes;
        lanes      = {{8{strb[1]}}, {8{strb[0]}}};
        lane_merge = ((old_val & ~lanes) | (wdata[15:0] & lanes)) & mask;
    endfunction

    pcs_clock_if  clk_bus ();

    reg_word_type amp_buffer_q;
    reg_word_type block_power_q;
    reg_word_type osc_trim_q;
    reg_word_type excitation_q;

    logic [31:0]  prdata_q;
    logic         pready_q;
    logic         pslverr_q;
    logic         flash_pwr_q;
    logic         adc_pwr_q;
    logic         conv1_pwr_q;
    logic         conv2_pwr_q;
    logic         amp1_pwr_q;
    logic         amp2_pwr_q;
    logic         amp1_buf_q;
    logic         amp2_buf_q;
    logic [4:0]   trim_q;
    logic [2:0]   isrc_q;
    logic signed [11:0] isrc_ua_q;

    // Address decode
    wire          setup_phase = psel && !penable;
    wire          write_take  = psel && penable && pready_q && pwrite;
    wire          hit_buffer  = paddr == byte_addr(`IDX_AMP_BUFFER);
    wire          hit_power   = paddr == byte_addr(`IDX_BLOCK_POWER);
    wire          hit_osc     = paddr == byte_addr(`IDX_OSC_TRIM);
    wire          hit_isrc    = paddr == byte_addr(`IDX_EXCITATION);
    wire          hit_status  = paddr == byte_addr(`IDX_CLOCK_STATUS);
    wire          hit_any     = hit_buffer || hit_power || hit_osc
                                || hit_isrc || hit_status;
    // Status is read-only; a write to it is refused
    wire          bad_access  = !hit_any || (hit_status && pwrite);

    wire reg_word_type status_word = {13'h0000,
                                      clk_bus.pin_driving,
                                      clk_bus.osc_running,
                                      clk_bus.internal_sel};

    // Read selection; unused positions are already zero in storage
    wire reg_word_type read_word =
        hit_buffer ? amp_buffer_q  :
        hit_power  ? block_power_q :
        hit_osc    ? osc_trim_q    :
        hit_isrc   ? excitation_q  :
        hit_status ? status_word   : 16'h0000;

    // Next values of the software registers
    wire reg_word_type amp_buffer_d = lane_merge(amp_buffer_q, pwdata, pstrb,
                                                 `MASK_AMP_BUFFER);
    wire reg_word_type block_power_d = lane_merge(block_power_q, pwdata, pstrb,
                                                  `MASK_BLOCK_POWER);
    // Reserved bits 5..4 are never stored, whatever software writes
    wire reg_word_type osc_trim_d = lane_merge(osc_trim_q, pwdata, pstrb,
                                               `MASK_OSC_TRIM);
    wire reg_word_type excitation_d = lane_merge(excitation_q, pwdata, pstrb,
                                                 `MASK_EXCITATION);

    // Zero-wait slave: answer in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= setup_phase;
            pslverr_q <= setup_phase && bad_access;
            if (setup_phase && !pwrite) begin
                prdata_q <= {16'h0000, read_word};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            amp_buffer_q  <= `RST_AMP_BUFFER;
            block_power_q <= `RST_BLOCK_POWER;
            osc_trim_q    <= `RST_OSC_TRIM;
            excitation_q  <= `RST_EXCITATION;
        end else if (write_take) begin
            if (hit_buffer) begin
                amp_buffer_q <= amp_buffer_d;
            end
            if (hit_power) begin
                block_power_q <= block_power_d;
            end
            if (hit_osc) begin
                osc_trim_q <= osc_trim_d;
            end
            if (hit_isrc) begin
                excitation_q <= excitation_d;
            end
        end
    end

    // Converter power bits double as the converter enables
    wire conv1_on = block_power_q[`BIT_CONV1_PWR];
    wire conv2_on = block_power_q[`BIT_CONV2_PWR];
    wire [2:0] isrc_code = excitation_q[`POS_ISRC_MSB:0];

    // Registered outputs; one cycle behind the register write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_pwr_q <= 1'b0;
            adc_pwr_q   <= 1'b0;
            conv1_pwr_q <= 1'b0;
            conv2_pwr_q <= 1'b0;
            amp1_pwr_q  <= 1'b0;
            amp2_pwr_q  <= 1'b0;
            amp1_buf_q  <= 1'b0;
            amp2_buf_q  <= 1'b0;
            trim_q      <= 5'h00;
            isrc_q      <= 3'h0;
            isrc_ua_q   <= 12'h000;
        end else begin
            flash_pwr_q <= block_power_q[`BIT_FLASH_PWR];
            adc_pwr_q   <= block_power_q[`BIT_ADC_PWR];
            conv1_pwr_q <= conv1_on;
            conv2_pwr_q <= conv2_on;
            amp1_pwr_q  <= block_power_q[`BIT_AMP1_PWR] || conv1_on;
            amp2_pwr_q  <= block_power_q[`BIT_AMP2_PWR] || conv2_on;
            amp1_buf_q  <= amp_buffer_q[`BIT_AMP1_BUF] || conv1_on;
            amp2_buf_q  <= amp_buffer_q[`BIT_AMP2_BUF] || conv2_on;
            trim_q      <= osc_trim_q[`POS_TRIM_MSB:`POS_TRIM_LSB];
            isrc_q      <= isrc_code;
            isrc_ua_q   <= 12'h000 - `ISRC_STEP_UA * {9'h000, isrc_code};
        end
    end

    assign clk_bus.clock_out_drive_en = osc_trim_q[`BIT_CLK_OUT_EN];

    pcs_clock_pin u_clock_pin (
        .pclk                (pclk),
        .presetn             (presetn),
        .clock_source_strap  (clock_source_strap),
        .shared_clock_pin_i  (shared_clock_pin_i),
        .shared_clock_pin_o  (shared_clock_pin_o),
        .shared_clock_pin_oe (shared_clock_pin_oe),
        .pin_clock_sync      (pin_clock_sync),
        .ctl                 (clk_bus.pin)
    );

    assign prdata                  = prdata_q;
    assign pready                  = pready_q;
    assign pslverr                 = pslverr_q;
    assign flash_program_power_en  = flash_pwr_q;
    assign converter_in_power_en   = adc_pwr_q;
    assign out_conv1_power_en      = conv1_pwr_q;
    assign out_conv2_power_en      = conv2_pwr_q;
    assign amp_pair1_power_en      = amp1_pwr_q;
    assign amp_pair2_power_en      = amp2_pwr_q;
    assign amp_pair1_buffer_mode   = amp1_buf_q;
    assign amp_pair2_buffer_mode   = amp2_buf_q;
    assign osc_run                 = clk_bus.osc_running;
    assign osc_trim_code           = trim_q;
    assign excitation_current_code = isrc_q;
    assign excitation_current_ua   = isrc_ua_q;

    // Checks

    a_isrc_step_value:
        assert property (@(posedge pclk) disable iff (!presetn)
            excitation_current_ua == 12'h000 - 12'h0a7 * {9'h000, excitation_current_code})
        else $error("excitation current not code times step");

    a_flash_power_follow:
        assert property (@(posedge pclk) disable iff (!presetn)
            write_take && hit_power
            |=> ##1 flash_program_power_en == $past(pwdata[12], 2) || !$past(pstrb[1], 2))
        else $error("flash power does not follow write");

    a_adc_power_follow:
        assert property (@(posedge pclk) disable iff (!presetn)
            ##1 converter_in_power_en == $past(block_power_q[8]))
        else $error("input converter power mismatch");

    a_conv_power_follow:
        assert property (@(posedge pclk) disable iff (!presetn)
            ##1 (out_conv2_power_en == $past(block_power_q[5]))
                && (out_conv1_power_en == $past(block_power_q[4])))
        else $error("output converter power mismatch");

    a_amp_power_off:
        assert property (@(posedge pclk) disable iff (!presetn)
            ##1 $past(block_power_q[1:0]) == 2'b00 && $past(block_power_q[5:4]) == 2'b00
            |-> !amp_pair1_power_en && !amp_pair2_power_en)
        else $error("amp pair powered while off");

    a_conv_forces_amps:
        assert property (@(posedge pclk) disable iff (!presetn)
            (!out_conv1_power_en || (amp_pair1_power_en && amp_pair1_buffer_mode))
            && (!out_conv2_power_en || (amp_pair2_power_en && amp_pair2_buffer_mode)))
        else $error("converter on without buffered amps");

    a_trim_follow:
        assert property (@(posedge pclk) disable iff (!presetn)
            write_take && hit_osc && pstrb[1]
            |=> ##1 osc_trim_code == $past(pwdata[12:8], 2))
        else $error("trim code did not follow write");

    a_strap_low_halt:
        assert property (@(posedge pclk) disable iff (!presetn)
            !clock_source_strap [*4] |-> !osc_run && !shared_clock_pin_oe)
        else $error("oscillator runs or pin driven with strap low");

    a_quiet_pin:
        assert property (@(posedge pclk) disable iff (!presetn)
            clk_bus.internal_sel && !osc_trim_q[0] |=> osc_run && !shared_clock_pin_oe)
        else $error("pin driven while clock out disabled");

    a_drive_pin:
        assert property (@(posedge pclk) disable iff (!presetn)
            clk_bus.internal_sel && osc_trim_q[0] |=> osc_run && shared_clock_pin_oe)
        else $error("clock not driven out when enabled");

    a_unused_zero:
        assert property (@(posedge pclk) disable iff (!presetn)
            (block_power_q & 16'heecc) == 16'h0000 && (osc_trim_q & 16'he0fe) == 16'h0000
            && (excitation_q[15:3] == 13'h0000) && (amp_buffer_q[15:2] == 14'h0000))
        else $error("unused bit holds a value");

    a_buffer_follow:
        assert property (@(posedge pclk) disable iff (!presetn)
            ##1 !$past(block_power_q[5])
            |-> amp_pair2_buffer_mode == $past(amp_buffer_q[1]))
        else $error("buffer mode mismatch");

    a_apb_answer:
        assert property (@(posedge pclk) disable iff (!presetn)
            psel && !penable |=> pready)
        else $error("no answer in first access cycle");

    a_amp_power_on:
        assert property (@(posedge pclk) disable iff (!presetn)
            ##1 (amp_pair1_power_en == $past(block_power_q[0] || block_power_q[4]))
                && (amp_pair2_power_en == $past(block_power_q[1] || block_power_q[5])))
        else $error("amp pair power mismatch");

    a_amp1_buffer_follow:
        assert property (@(posedge pclk) disable iff (!presetn)
            ##1 !$past(block_power_q[4])
            |-> amp_pair1_buffer_mode == $past(amp_buffer_q[0]))
        else $error("buffer mode mismatch on pair one");

    a_slave_error:
        assert property (@(posedge pclk) disable iff (!presetn)
            setup_phase |=> pslverr == $past(bad_access))
        else $error("slave error does not match decode");

    a_halted_pin_low:
        assert property (@(posedge pclk) disable iff (!presetn)
            !osc_run |=> !shared_clock_pin_o)
        else $error("clock out moves while halted");

    a_clock_toggles:
        assert property (@(posedge pclk) disable iff (!presetn)
            osc_run |=> $changed(shared_clock_pin_o))
        else $error("internal clock stands still");

    a_enable_needs_strap:
        assert property (@(posedge pclk) disable iff (!presetn)
            !clk_bus.internal_sel |=> !shared_clock_pin_oe)
        else $error("pin driven with external clock strapped");

    a_isrc_code_follow:
        assert property (@(posedge pclk) disable iff (!presetn)
            ##1 excitation_current_code == $past(excitation_q[2:0]))
        else $error("excitation code does not follow register");

endmodule // power_clock_source_control

`default_nettype wire

// [tb/power_clock_source_control_tb.sv]
// Self-checking bench for the power, oscillator and excitation register bank
`timescale 1ns/1ps
`default_nettype none
`include "pcs_map.svh"

module power_clock_source_control_tb;
    import pcs_pkg::*;

    logic               pclk;
    logic               presetn;
    logic [11:0]        paddr;
    logic               psel;
    logic               penable;
    logic               pwrite;
    logic [31:0]        pwdata;
    logic [3:0]         pstrb;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic               clock_source_strap;
    logic               shared_clock_pin_i;
    logic               shared_clock_pin_o;
    logic               shared_clock_pin_oe;
    logic               pin_clock_sync;
    logic [7:0]         pwr_outs;
    logic               osc_run;
    logic [4:0]         osc_trim_code;
    logic [2:0]         excitation_current_code;
    logic signed [11:0] excitation_current_ua;
    int                 failures = 0;
    int                 checks = 0;
    logic [31:0]        rdata;
    logic               rerr;
    logic               tog_a;
    logic [11:0]        exp_ua;
    logic [15:0]        pw_val;
    logic [7:0]         exp_p;

    localparam logic [11:0] A_BUF  = 12'({`IDX_AMP_BUFFER, 2'b00});
    localparam logic [11:0] A_PWR  = 12'({`IDX_BLOCK_POWER, 2'b00});
    localparam logic [11:0] A_OSC  = 12'({`IDX_OSC_TRIM, 2'b00});
    localparam logic [11:0] A_EXC  = 12'({`IDX_EXCITATION, 2'b00});
    localparam logic [11:0] A_STAT = 12'({`IDX_CLOCK_STATUS, 2'b00});

    power_clock_source_control i_power_clock_source_control (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .clock_source_strap(clock_source_strap),
        .shared_clock_pin_i(shared_clock_pin_i), .shared_clock_pin_o(shared_clock_pin_o),
        .shared_clock_pin_oe(shared_clock_pin_oe), .pin_clock_sync(pin_clock_sync),
        .flash_program_power_en(pwr_outs[7]), .converter_in_power_en(pwr_outs[6]),
        .out_conv2_power_en(pwr_outs[5]), .out_conv1_power_en(pwr_outs[4]),
        .amp_pair2_power_en(pwr_outs[3]), .amp_pair1_power_en(pwr_outs[2]),
        .amp_pair2_buffer_mode(pwr_outs[1]), .amp_pair1_buffer_mode(pwr_outs[0]),
        .osc_run(osc_run), .osc_trim_code(osc_trim_code),
        .excitation_current_code(excitation_current_code),
        .excitation_current_ua(excitation_current_ua)
    );

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One APB transfer; only the watchdog bounds the wait for pready
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                       input logic [3:0] st);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wd;
        pstrb   <= st;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdata = prdata;
        rerr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp, input logic eerr);
        apb(1'b0, addr, 32'h0000_0000, 4'h0);
        check(rdata, exp, "read data");
        check({31'h0, rerr}, {31'h0, eerr}, "slave error");
    endtask

    // Expected power outputs: an enabled converter forces its amps on and buffered
    function automatic logic [7:0] exp_pwr(input logic [15:0] pw, input logic [15:0] bf);
        return {pw[12], pw[8], pw[5], pw[4], pw[1] | pw[5], pw[0] | pw[4],
                bf[1] | pw[5], bf[0] | pw[4]};
    endfunction

    task automatic tally_and_finish;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        $display("wrong value at %0t: run did not finish", $time);
        tally_and_finish;
    end

    logic [11:0] addrs [4] = '{A_BUF, A_PWR, A_OSC, A_EXC};
    logic [31:0] wvals [4] = '{32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffcf, 32'hffff_ffff};
    logic [15:0] masks [4] = '{`MASK_AMP_BUFFER, `MASK_BLOCK_POWER, `MASK_OSC_TRIM,
                               `MASK_EXCITATION};
    int          pbits [6] = '{`BIT_FLASH_PWR, `BIT_ADC_PWR, `BIT_CONV2_PWR,
                               `BIT_CONV1_PWR, `BIT_AMP2_PWR, `BIT_AMP1_PWR};

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
        clock_source_strap = 1'b0;
        shared_clock_pin_i = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;

        // Reset values, unused bits dropped, reserved oscillator bits kept at zero
        for (int i = 0; i < 4; i++) begin
            rd_chk(addrs[i], 32'h0000_0000, 1'b0);
            apb(1'b1, addrs[i], wvals[i], 4'hf);
            rd_chk(addrs[i], {16'h0000, masks[i]}, 1'b0);
            apb(1'b1, addrs[i], 32'h0000_0000, 4'hf);
        end
        apb(1'b1, A_PWR, 32'h0000_1133, 4'h2);
        rd_chk(A_PWR, 32'h0000_1100, 1'b0);
        rd_chk(12'h100, 32'h0000_0000, 1'b1);
        apb(1'b1, A_STAT, 32'h0000_ffff, 4'hf);
        check({31'h0, rerr}, 32'h0000_0001, "status write refused");
        $display("test registers done");

        // Excitation code and current for every code
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, A_EXC, 32'hffff_fff8 | 32'(c), 4'hf);
            repeat (2) @(posedge pclk);
            #1;
            check({29'h0, excitation_current_code}, 32'(c), "excitation code");
            exp_ua = 12'h000 - 12'h0a7 * 12'(c);
            check({20'h0, excitation_current_ua}, {20'h0, exp_ua}, "current");
        end
        $display("test excitation done");

        // Each power bit alone, with and without buffer bits, plus the converter override
        for (int b = 0; b < 2; b++) begin
            apb(1'b1, A_BUF, 32'(b * 3), 4'hf);
            for (int i = 0; i < 7; i++) begin
                pw_val = (i < 6) ? 16'(1) << pbits[i] : 16'h1133;
                exp_p  = exp_pwr(pw_val, 16'(b * 3));
                apb(1'b1, A_PWR, {16'h0000, pw_val}, 4'hf);
                repeat (2) @(posedge pclk);
                #1;
                check({30'h0, pwr_outs[7:6]}, {30'h0, exp_p[7:6]}, "pwr");
                check({30'h0, pwr_outs[5:4]}, {30'h0, exp_p[5:4]}, "conv");
                check({30'h0, pwr_outs[3:2]}, {30'h0, exp_p[3:2]}, "amp");
                check({30'h0, pwr_outs[1:0]}, {30'h0, exp_p[1:0]}, "buf");
            end
        end
        $display("test power done");

        // Trim codes 0 to 30 in steps of five: both signs and the positive extreme
        for (int t = 0; t < 32; t += 5) begin
            apb(1'b1, A_OSC, 32'(t) << `POS_TRIM_LSB, 4'hf);
            repeat (2) @(posedge pclk);
            #1;
            check({27'h0, osc_trim_code}, 32'(t), "trim code");
        end
        $display("test trim done");

        // Strap low: oscillator halted, pin is input even with the enable bit set
        apb(1'b1, A_OSC, 32'h0000_0001, 4'hf);
        repeat (5) @(posedge pclk);
        #1;
        check({30'h0, osc_run, shared_clock_pin_oe}, 32'h0, "halted");
        check({31'h0, shared_clock_pin_o}, 32'h0, "pin low");
        rd_chk(A_STAT, 32'h0000_0000, 1'b0);
        for (int k = 0; k < 4; k++) begin
            @(posedge pclk);
            shared_clock_pin_i <= ~shared_clock_pin_i;
            repeat (4) @(posedge pclk);
            #1;
            check({31'h0, pin_clock_sync}, {31'h0, shared_clock_pin_i}, "ext clock");
        end
        // Strap high with enable set: oscillator runs and drives the pin
        @(posedge pclk);
        clock_source_strap <= 1'b1;
        repeat (5) @(posedge pclk);
        #1;
        check({30'h0, osc_run, shared_clock_pin_oe}, 32'h3, "driving");
        tog_a = shared_clock_pin_o;
        @(posedge pclk);
        #1;
        check({31'h0, tog_a ^ shared_clock_pin_o}, 32'h1, "clock toggles");
        rd_chk(A_STAT, 32'h0000_0007, 1'b0);
        // Strap high with enable clear: runs, driver off
        apb(1'b1, A_OSC, 32'h0000_0000, 4'hf);
        repeat (3) @(posedge pclk);
        #1;
        check({30'h0, osc_run, shared_clock_pin_oe}, 32'h2, "quiet");
        rd_chk(A_STAT, 32'h0000_0003, 1'b0);
        $display("test clock pin done");
        tally_and_finish;
    end
endmodule // power_clock_source_control_tb

`default_nettype wire
